// ### design/cycle_timer.sv
`timescale 1ns/10ps
module cycle_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Start
  input wire logic load,
  input wire float_exec_pkg::lat_type length,
  // Status
  output logic busy,
  output logic fire
);

  float_exec_pkg::lat_type count;

  // Counts down from length; fire marks the last cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= float_exec_pkg::LAT_RESET;
    end else if (load) begin
      count <= length;
    end else if (count != float_exec_pkg::LAT_RESET) begin
      count <= count - 7'h01;
    end
  end

  assign busy = (count != float_exec_pkg::LAT_RESET);
  assign fire = (count == 7'h01);

endmodule

// ### design/float_exec_timing.sv
`timescale 1ns/10ps
module float_exec_timing (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Issue
  input wire logic issue_valid,
  output logic issue_ready,
  input wire float_exec_pkg::op_type op,
  input wire logic double_prec,
  input wire logic short_vector,
  // Modes
  input wire logic fast_float_mode,
  input wire logic flush_to_zero,
  // Operand data class
  input wire logic operand_special,
  input wire logic [1:0] subnormal_count,
  input wire logic inter_subnormal,
  input wire logic result_subnormal,
  input wire logic [5:0] extra_work,
  input wire logic penalty_high,
  // Fast path data
  input wire logic [31:0] fast_value,
  input wire logic upper_half,
  input wire logic [63:0] reg_old,
  // Completion
  output logic done,
  output logic done_fast,
  output logic busy,
  output logic [63:0] wr_data,
  output logic wr_upper,
  output float_exec_pkg::lat_type latency_taken
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_COP = 3'b010,
    ST_FAST = 3'b100
  } state_type;

  state_type state;
  state_type next_state;

  float_exec_pkg::lat_type lat_lo;
  float_exec_pkg::lat_type lat_hi;
  float_exec_pkg::lat_type span;
  float_exec_pkg::lat_type base_lat;
  float_exec_pkg::lat_type pen_lat;
  float_exec_pkg::lat_type cop_lat;
  float_exec_pkg::lat_type work;
  logic two_point;
  logic has_op_pen;
  logic has_res_pen;
  logic has_int_pen;
  logic fast_op;
  logic fast_ok;
  logic accept;
  logic cop_load;
  logic fast_load;
  logic cop_busy;
  logic cop_fire;
  logic fast_busy;
  logic fast_fire;

  // Latency window per operation and precision
  always_comb begin
    lat_lo = float_exec_pkg::MOVE_LAT;
    lat_hi = float_exec_pkg::MOVE_LAT;
    two_point = 1'b0;
    has_op_pen = 1'b0;
    has_res_pen = 1'b0;
    has_int_pen = 1'b0;
    unique case (op)
      float_exec_pkg::float_add_op: begin
        lat_lo = float_exec_pkg::ADD_MIN;
        lat_hi = float_exec_pkg::ADD_MAX;
        has_op_pen = 1'b1;
        has_res_pen = 1'b1;
      end
      float_exec_pkg::float_multiply_op: begin
        lat_lo = double_prec ? float_exec_pkg::MUL_D_MIN : float_exec_pkg::MUL_S_MIN;
        lat_hi = double_prec ? float_exec_pkg::MUL_D_MAX : float_exec_pkg::MUL_S_MAX;
        has_op_pen = 1'b1;
        has_res_pen = 1'b1;
      end
      float_exec_pkg::multiply_accumulate_op: begin
        // Multiply and add, less one cycle
        lat_lo = (double_prec ? float_exec_pkg::MUL_D_MIN : float_exec_pkg::MUL_S_MIN)
          + float_exec_pkg::ADD_MIN - 7'h01;
        lat_hi = (double_prec ? float_exec_pkg::MUL_D_MAX : float_exec_pkg::MUL_S_MAX)
          + float_exec_pkg::ADD_MAX - 7'h01;
        has_op_pen = 1'b1;
        has_res_pen = 1'b1;
        has_int_pen = 1'b1;
      end
      float_exec_pkg::float_divide_op: begin
        lat_lo = double_prec ? float_exec_pkg::DIV_D_MIN : float_exec_pkg::DIV_S_MIN;
        lat_hi = double_prec ? float_exec_pkg::DIV_D_MAX : float_exec_pkg::DIV_S_MAX;
        has_op_pen = 1'b1;
        has_res_pen = 1'b1;
      end
      float_exec_pkg::float_square_root_op: begin
        lat_lo = double_prec ? float_exec_pkg::SQRT_D_MIN : float_exec_pkg::SQRT_S_MIN;
        lat_hi = double_prec ? float_exec_pkg::SQRT_D_MAX : float_exec_pkg::SQRT_S_MAX;
        has_op_pen = 1'b1;
      end
      float_exec_pkg::move_op, float_exec_pkg::abs_neg_op: begin
        lat_lo = float_exec_pkg::MOVE_LAT;
        lat_hi = float_exec_pkg::MOVE_LAT;
      end
      float_exec_pkg::float_compare_op: begin
        lat_lo = float_exec_pkg::CMP_SHORT;
        lat_hi = float_exec_pkg::CMP_LONG;
        two_point = 1'b1;
      end
      float_exec_pkg::int_to_float_op: begin
        lat_lo = float_exec_pkg::INT_TO_F_LAT;
        lat_hi = float_exec_pkg::INT_TO_F_LAT;
      end
      float_exec_pkg::float_to_int_op: begin
        lat_lo = float_exec_pkg::F_TO_INT_LAT;
        lat_hi = float_exec_pkg::F_TO_INT_LAT;
      end
      float_exec_pkg::fix_to_float_op: begin
        lat_lo = float_exec_pkg::FIX_TO_F_LAT;
        lat_hi = float_exec_pkg::FIX_TO_F_LAT;
      end
      float_exec_pkg::float_to_fix_op: begin
        lat_lo = double_prec ? float_exec_pkg::F_TO_FIX_D_LAT
          : float_exec_pkg::F_TO_FIX_S_LAT;
        lat_hi = lat_lo;
      end
      float_exec_pkg::single_to_double_convert: begin
        lat_lo = float_exec_pkg::S_TO_D_LAT;
        lat_hi = float_exec_pkg::S_TO_D_LAT;
        has_op_pen = 1'b1;
      end
      float_exec_pkg::double_to_single_convert: begin
        lat_lo = float_exec_pkg::D_TO_S_LAT;
        lat_hi = float_exec_pkg::D_TO_S_LAT;
        has_int_pen = 1'b1;
      end
      default: begin
        lat_lo = float_exec_pkg::MOVE_LAT;
        lat_hi = float_exec_pkg::MOVE_LAT;
      end
    endcase
  end

  // Early termination picks a point inside the window
  always_comb begin
    span = lat_hi - lat_lo;
    work = float_exec_pkg::lat_type'(extra_work);
    if (operand_special) begin
      base_lat = lat_lo;
    end else if (two_point) begin
      base_lat = (work != float_exec_pkg::LAT_RESET) ? lat_hi : lat_lo;
    end else if (work > span) begin
      base_lat = lat_hi;
    end else begin
      base_lat = lat_lo + work;
    end
  end

  // Subnormal penalties, only with flush-to-zero off
  always_comb begin
    pen_lat = float_exec_pkg::LAT_RESET;
    if (!flush_to_zero && !operand_special) begin
      if (has_op_pen) begin
        unique case (subnormal_count)
          2'h1: pen_lat = penalty_high ? float_exec_pkg::OP1_PEN_HI
            : float_exec_pkg::OP1_PEN_LO;
          2'h2, 2'h3: pen_lat = penalty_high ? float_exec_pkg::OP2_PEN_HI
            : float_exec_pkg::OP2_PEN_LO;
          2'h0: pen_lat = float_exec_pkg::LAT_RESET;
        endcase
      end
      if (has_int_pen && (inter_subnormal || subnormal_count == 2'h3)) begin
        pen_lat = pen_lat + (penalty_high ? float_exec_pkg::INTER_PEN_HI
          : float_exec_pkg::INTER_PEN_LO);
      end
      if (has_res_pen && result_subnormal) begin
        pen_lat = pen_lat + (penalty_high ? float_exec_pkg::RES_PEN_HI
          : float_exec_pkg::RES_PEN_LO);
      end
    end
  end

  // Decode cycles are already inside every figure
  assign cop_lat = base_lat + pen_lat;

  // Fast path selection
  always_comb begin
    unique case (op)
      float_exec_pkg::float_add_op, float_exec_pkg::abs_neg_op,
      float_exec_pkg::float_multiply_op, float_exec_pkg::multiply_accumulate_op,
      float_exec_pkg::float_compare_op, float_exec_pkg::int_to_float_op,
      float_exec_pkg::float_to_int_op, float_exec_pkg::fix_to_float_op,
      float_exec_pkg::float_to_fix_op: fast_op = 1'b1;
      default: fast_op = 1'b0;
    endcase
  end

  assign fast_ok = !double_prec && fast_float_mode && !short_vector && fast_op;

  // One instruction in flight; next taken only on completion
  assign issue_ready = (state == ST_IDLE) || cop_fire || fast_fire;
  assign accept = issue_valid && issue_ready;
  assign cop_load = accept && !fast_ok;
  assign fast_load = accept && fast_ok;

  cycle_timer cop_timer (
    .clk(clk),
    .rst_b(rst_b),
    .load(cop_load),
    .length(cop_lat),
    .busy(cop_busy),
    .fire(cop_fire)
  );

  cycle_timer fast_timer (
    .clk(clk),
    .rst_b(rst_b),
    .load(fast_load),
    .length(float_exec_pkg::FAST_LAT),
    .busy(fast_busy),
    .fire(fast_fire)
  );

  // Engine selection state
  always_comb begin
    next_state = state;
    if (accept) begin
      next_state = fast_ok ? ST_FAST : ST_COP;
    end else if (cop_fire || fast_fire) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Done flags only at completion, never early; fast path wr_data changes the cycle after issue
  assign done = cop_fire || fast_fire;
  assign done_fast = fast_fire;
  assign busy = cop_busy || fast_busy;

  // Merge 32-bit result into one half
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_data <= float_exec_pkg::WORD_RESET;
      wr_upper <= 1'b0;
    end else if (fast_load) begin
      wr_data <= upper_half ? {fast_value, reg_old[31:0]}
        : {reg_old[63:32], fast_value};
      wr_upper <= upper_half;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latency_taken <= float_exec_pkg::LAT_RESET;
    end else if (accept) begin
      latency_taken <= fast_ok ? float_exec_pkg::FAST_LAT : cop_lat;
    end
  end

  // Elapsed cycles of the running instruction
  float_exec_pkg::lat_type watch;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      watch <= float_exec_pkg::LAT_RESET;
    end else if (accept) begin
      watch <= 7'h01;
    end else if (state != ST_IDLE) begin
      watch <= watch + 7'h01;
    end
  end

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rst_b);

  sequence fast_wait;
    !done_fast [*6];
  endsequence

  sequence fast_finish;
    done_fast && done;
  endsequence

  a_single_in_flight: assert property (
    (cop_busy && !cop_fire) |-> !issue_ready
  ) else $error("issue accepted while coprocessor busy");

  a_done_on_time: assert property (
    done |-> watch == latency_taken
  ) else $error("completion not at recorded latency");

  a_fast_seven: assert property (
    fast_load |-> ##1 fast_wait ##1 fast_finish
  ) else $error("fast path not exactly seven cycles");

  a_fast_gate: assert property (
    (accept && (double_prec || !fast_float_mode || short_vector)) |=> !fast_busy && cop_busy
  ) else $error("fast path took an ineligible instruction");

  a_fast_op_set: assert property (
    fast_load |-> op != float_exec_pkg::move_op && op != float_exec_pkg::float_divide_op
      && op != float_exec_pkg::float_square_root_op
  ) else $error("fast path took an excluded operation");

  a_route_cop: assert property (
    cop_load |=> cop_busy && state == ST_COP
  ) else $error("ineligible instruction not on coprocessor");

  a_ftz_no_penalty: assert property (
    (cop_load && flush_to_zero) |=> latency_taken == $past(base_lat)
  ) else $error("penalty added with flush-to-zero on");

  a_compare_lat: assert property (
    (cop_load && op == float_exec_pkg::float_compare_op) |=>
      latency_taken == 7'h04 || latency_taken == 7'h07
  ) else $error("compare latency not four or seven");

  a_move_lat: assert property (
    (cop_load && op == float_exec_pkg::move_op) |=> latency_taken == 7'h04
  ) else $error("move latency not four");

  a_special_short: assert property (
    (cop_load && operand_special) |-> cop_lat == lat_lo
  ) else $error("special operand not on short path");

  a_keep_half: assert property (
    (fast_load && !upper_half) |=> wr_data[63:32] == $past(reg_old[63:32])
  ) else $error("untouched half of register changed");

  a_result_pen: assert property (
    (cop_load && op == float_exec_pkg::float_divide_op && !flush_to_zero
      && !operand_special && subnormal_count == 2'h0 && result_subnormal)
      |-> cop_lat >= base_lat + 7'h06 && cop_lat <= base_lat + 7'h07
  ) else $error("result penalty not six to seven");

endmodule

// ### shared/float_exec_pkg.sv
// What this block does
// - Coprocessor finishes each instruction fully before accepting the next.
// - Coprocessor results are visible only after the producer completes.
// - Two decode cycles separate coprocessor instructions; latencies include them.
// - Latency depends on operation and on operand class: normal, subnormal, special.
// - Special operands take a separate short path, no longer than normal minimum.
// - Single normal: add 9-10, mac 18-21, divide 20-37, root 19-33.
// - Double normal: add 9-10, mac 19-26, divide 29-65, root 29-60.
// - Multiply takes 10-12 cycles single, 11-17 cycles double.
// - Every compare takes four or seven cycles in either precision.
// - Fixed latencies for moves, conversions and precision changes.
// - Early termination when no more work is needed gives the ranges.
// - Subnormal penalties apply only while flush-to-zero is off.
// - Subnormal result adds six to seven cycles on add, multiply, multiply-add and divide.
// - Subnormal operands add 5-6 for one, 9-10 for two or three; three also adds the intermediate penalty on multiply-add and double-to-single.
// - Subnormal multiply-add intermediate adds 11 to 13 cycles.
// - Multiply-add takes multiply plus add, less one cycle.
// - Fast path only for single precision, fast mode on, not short vector.
// - Fast path accepts only its listed single-precision operations.
// - Fast path writes 32 bits into one half of a 64-bit register.
// - Fast path never forwards early; every instruction takes exactly 7 cycles. Here wr_data changes the cycle after issue, six cycles before done_fast.
package float_exec_pkg;

  typedef logic [6:0] lat_type;

  typedef enum logic [3:0] {
    float_add_op = 4'h0,
    float_multiply_op = 4'h1,
    multiply_accumulate_op = 4'h2,
    float_divide_op = 4'h3,
    float_square_root_op = 4'h4,
    move_op = 4'h5,
    abs_neg_op = 4'h6,
    float_compare_op = 4'h7,
    int_to_float_op = 4'h8,
    float_to_int_op = 4'h9,
    fix_to_float_op = 4'hA,
    float_to_fix_op = 4'hB,
    single_to_double_convert = 4'hC,
    double_to_single_convert = 4'hD
  } op_type;

  localparam lat_type DECODE_CYCLES = 7'h02;
  localparam lat_type ADD_MIN = 7'h09;
  localparam lat_type ADD_MAX = 7'h0A;
  localparam lat_type MUL_S_MIN = 7'h0A;
  localparam lat_type MUL_S_MAX = 7'h0C;
  localparam lat_type MUL_D_MIN = 7'h0B;
  localparam lat_type MUL_D_MAX = 7'h11;
  localparam lat_type DIV_S_MIN = 7'h14;
  localparam lat_type DIV_S_MAX = 7'h25;
  localparam lat_type DIV_D_MIN = 7'h1D;
  localparam lat_type DIV_D_MAX = 7'h41;
  localparam lat_type SQRT_S_MIN = 7'h13;
  localparam lat_type SQRT_S_MAX = 7'h21;
  localparam lat_type SQRT_D_MIN = 7'h1D;
  localparam lat_type SQRT_D_MAX = 7'h3C;
  localparam lat_type MOVE_LAT = 7'h04;
  localparam lat_type CMP_SHORT = 7'h04;
  localparam lat_type CMP_LONG = 7'h07;
  localparam lat_type INT_TO_F_LAT = 7'h09;
  localparam lat_type F_TO_INT_LAT = 7'h08;
  localparam lat_type FIX_TO_F_LAT = 7'h09;
  localparam lat_type F_TO_FIX_S_LAT = 7'h06;
  localparam lat_type F_TO_FIX_D_LAT = 7'h08;
  localparam lat_type S_TO_D_LAT = 7'h05;
  localparam lat_type D_TO_S_LAT = 7'h07;
  localparam lat_type FAST_LAT = 7'h07;
  localparam lat_type RES_PEN_LO = 7'h06;
  localparam lat_type RES_PEN_HI = 7'h07;
  localparam lat_type OP1_PEN_LO = 7'h05;
  localparam lat_type OP1_PEN_HI = 7'h06;
  localparam lat_type OP2_PEN_LO = 7'h09;
  localparam lat_type OP2_PEN_HI = 7'h0A;
  localparam lat_type INTER_PEN_LO = 7'h0B;
  localparam lat_type INTER_PEN_HI = 7'h0D;
  localparam lat_type LAT_RESET = 7'h00;
  localparam logic [63:0] WORD_RESET = 64'h0;

endpackage

// ### tb/issue_model.sv
`timescale 1ns/10ps
module issue_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Request from bench
  input wire logic go,
  // Block handshake
  input wire logic issue_ready,
  input wire logic done,
  input wire logic done_fast,
  output logic issue_valid,
  // Outcome
  output logic idle,
  output logic fast_seen,
  output logic [7:0] cycles
);
  logic counting;
  logic [7:0] cnt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      issue_valid <= 1'b0;
      counting <= 1'b0;
      cnt <= 8'h00;
      idle <= 1'b1;
      fast_seen <= 1'b0;
      cycles <= 8'h00;
    end else if (issue_valid && issue_ready) begin
      issue_valid <= 1'b0;
      counting <= 1'b1;
      cnt <= 8'h01;
    end else if (counting) begin
      if (done) begin
        counting <= 1'b0;
        idle <= 1'b1;
        cycles <= cnt;
        fast_seen <= done_fast;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end else if (go && idle) begin
      issue_valid <= 1'b1;
      idle <= 1'b0;
    end
  end
endmodule

// ### tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic clk, rst_b, go, issue_valid, issue_ready, double_prec, short_vector;
  logic fast_float_mode, flush_to_zero, operand_special, inter_subnormal;
  logic result_subnormal, penalty_high, upper_half, done, done_fast, busy, wr_upper;
  logic idle, fast_seen;
  logic [1:0] subnormal_count;
  logic [5:0] extra_work;
  logic [31:0] fast_value;
  logic [63:0] reg_old, wr_data;
  logic [7:0] cycles;
  float_exec_pkg::op_type op;
  float_exec_pkg::lat_type latency_taken;
  int mismatches, checks;

  float_exec_timing i_float_exec_timing (.clk(clk), .rst_b(rst_b),
    .issue_valid(issue_valid), .issue_ready(issue_ready), .op(op),
    .double_prec(double_prec), .short_vector(short_vector),
    .fast_float_mode(fast_float_mode), .flush_to_zero(flush_to_zero),
    .operand_special(operand_special), .subnormal_count(subnormal_count),
    .inter_subnormal(inter_subnormal), .result_subnormal(result_subnormal),
    .extra_work(extra_work), .penalty_high(penalty_high), .fast_value(fast_value),
    .upper_half(upper_half), .reg_old(reg_old), .done(done), .done_fast(done_fast),
    .busy(busy), .wr_data(wr_data), .wr_upper(wr_upper), .latency_taken(latency_taken));

  issue_model i_issue_model (.clk(clk), .rst_b(rst_b), .go(go), .issue_ready(issue_ready),
    .done(done), .done_fast(done_fast), .issue_valid(issue_valid), .idle(idle),
    .fast_seen(fast_seen), .cycles(cycles));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Mode bits: double, short vector, fast mode, flush to zero
  task automatic mode(input logic [3:0] m);
    @(posedge clk);
    {double_prec, short_vector, fast_float_mode, flush_to_zero} <= m;
  endtask

  // Class bits: special, subnormal count, intermediate, result, high penalty
  task automatic start(input float_exec_pkg::op_type o, input logic [5:0] cls,
                       input logic [5:0] ex);
    @(posedge clk);
    op <= o;
    {operand_special, subnormal_count, inter_subnormal, result_subnormal, penalty_high} <= cls;
    extra_work <= ex;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic finish_run(input logic [7:0] exp, input logic fst);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (idle !== 1'b1 && n < 200);
    chk("idle", 64'h1, 64'(idle));
    chk("cycles", 64'(exp), 64'(cycles));
    chk("latency_taken", 64'(exp[6:0]), 64'(latency_taken));
    chk("done_fast", 64'(fst), 64'(fast_seen));
  endtask

  task automatic run(input float_exec_pkg::op_type o, input logic [5:0] cls,
                     input logic [5:0] ex, input logic [7:0] exp, input logic fst);
    start(o, cls, ex);
    finish_run(exp, fst);
  endtask

  task automatic t_fixed;
    mode(4'h0);
    run(float_exec_pkg::move_op, 6'h00, 6'h3F, 8'h04, 1'b0);
    run(float_exec_pkg::abs_neg_op, 6'h00, 6'h3F, 8'h04, 1'b0);
    run(float_exec_pkg::int_to_float_op, 6'h00, 6'h3F, 8'h09, 1'b0);
    run(float_exec_pkg::float_to_int_op, 6'h00, 6'h3F, 8'h08, 1'b0);
    run(float_exec_pkg::fix_to_float_op, 6'h00, 6'h3F, 8'h09, 1'b0);
    run(float_exec_pkg::float_to_fix_op, 6'h00, 6'h3F, 8'h06, 1'b0);
    run(float_exec_pkg::single_to_double_convert, 6'h00, 6'h00, 8'h05, 1'b0);
    run(float_exec_pkg::double_to_single_convert, 6'h00, 6'h00, 8'h07, 1'b0);
    run(float_exec_pkg::float_compare_op, 6'h08, 6'h00, 8'h04, 1'b0);
    run(float_exec_pkg::float_compare_op, 6'h00, 6'h01, 8'h07, 1'b0);
    mode(4'h8);
    run(float_exec_pkg::float_to_fix_op, 6'h00, 6'h3F, 8'h08, 1'b0);
    run(float_exec_pkg::float_compare_op, 6'h00, 6'h00, 8'h04, 1'b0);
    run(float_exec_pkg::float_compare_op, 6'h00, 6'h3F, 8'h07, 1'b0);
  endtask

  task automatic t_ranges;
    float_exec_pkg::op_type ops [5] = '{float_exec_pkg::float_add_op,
      float_exec_pkg::float_multiply_op, float_exec_pkg::multiply_accumulate_op,
      float_exec_pkg::float_divide_op, float_exec_pkg::float_square_root_op};
    logic [7:0] lo [10] = '{8'h09, 8'h0A, 8'h12, 8'h14, 8'h13, 8'h09, 8'h0B, 8'h13, 8'h1D, 8'h1D};
    logic [7:0] hi [10] = '{8'h0A, 8'h0C, 8'h15, 8'h25, 8'h21, 8'h0A, 8'h11, 8'h1A, 8'h41, 8'h3C};
    for (int d = 0; d < 2; d++) begin
      mode({d[0], 3'b000});
      for (int i = 0; i < 5; i++) begin
        run(ops[i], 6'h00, 6'h00, lo[d * 5 + i], 1'b0);
        run(ops[i], 6'h00, 6'h3F, hi[d * 5 + i], 1'b0);
        run(ops[i], 6'h20, 6'h3F, lo[d * 5 + i], 1'b0);
      end
    end
    run(float_exec_pkg::float_add_op, 6'h00, 6'h01, 8'h0A, 1'b0);
  endtask

  task automatic t_penalty;
    mode(4'h0);
    run(float_exec_pkg::float_add_op, 6'h08, 6'h00, 8'h0E, 1'b0);
    run(float_exec_pkg::float_add_op, 6'h09, 6'h00, 8'h0F, 1'b0);
    run(float_exec_pkg::float_add_op, 6'h10, 6'h00, 8'h12, 1'b0);
    run(float_exec_pkg::float_add_op, 6'h11, 6'h00, 8'h13, 1'b0);
    run(float_exec_pkg::float_add_op, 6'h02, 6'h00, 8'h0F, 1'b0);
    run(float_exec_pkg::float_add_op, 6'h03, 6'h00, 8'h10, 1'b0);
    run(float_exec_pkg::float_add_op, 6'h2B, 6'h00, 8'h09, 1'b0);
    run(float_exec_pkg::multiply_accumulate_op, 6'h18, 6'h00, 8'h26, 1'b0);
    run(float_exec_pkg::multiply_accumulate_op, 6'h19, 6'h00, 8'h29, 1'b0);
    run(float_exec_pkg::multiply_accumulate_op, 6'h04, 6'h00, 8'h1D, 1'b0);
    run(float_exec_pkg::multiply_accumulate_op, 6'h14, 6'h00, 8'h26, 1'b0);
    run(float_exec_pkg::float_square_root_op, 6'h02, 6'h00, 8'h13, 1'b0);
    run(float_exec_pkg::float_divide_op, 6'h03, 6'h00, 8'h1B, 1'b0);
    run(float_exec_pkg::double_to_single_convert, 6'h04, 6'h00, 8'h12, 1'b0);
    run(float_exec_pkg::single_to_double_convert, 6'h08, 6'h00, 8'h0A, 1'b0);
    run(float_exec_pkg::float_compare_op, 6'h08, 6'h00, 8'h04, 1'b0);
    mode(4'h1);
    run(float_exec_pkg::float_add_op, 6'h0B, 6'h00, 8'h09, 1'b0);
    run(float_exec_pkg::multiply_accumulate_op, 6'h19, 6'h00, 8'h12, 1'b0);
  endtask

  task automatic t_fast;
    float_exec_pkg::op_type fops [9] = '{float_exec_pkg::float_add_op,
      float_exec_pkg::abs_neg_op, float_exec_pkg::float_multiply_op,
      float_exec_pkg::multiply_accumulate_op, float_exec_pkg::float_compare_op,
      float_exec_pkg::int_to_float_op, float_exec_pkg::float_to_int_op,
      float_exec_pkg::fix_to_float_op, float_exec_pkg::float_to_fix_op};
    mode(4'h2);
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      upper_half <= i[0];
      run(fops[i], 6'h19, 6'h3F, 8'h07, 1'b1);
      if (i[0]) chk("wr_data", {fast_value, reg_old[31:0]}, wr_data);
      else chk("wr_data", {reg_old[63:32], fast_value}, wr_data);
      chk("wr_upper", 64'(i[0]), 64'(wr_upper));
    end
    run(float_exec_pkg::float_divide_op, 6'h00, 6'h00, 8'h14, 1'b0);
    run(float_exec_pkg::float_square_root_op, 6'h00, 6'h00, 8'h13, 1'b0);
    run(float_exec_pkg::move_op, 6'h00, 6'h00, 8'h04, 1'b0);
    run(float_exec_pkg::double_to_single_convert, 6'h00, 6'h00, 8'h07, 1'b0);
    mode(4'hA);
    run(float_exec_pkg::float_add_op, 6'h00, 6'h00, 8'h09, 1'b0);
    mode(4'h6);
    run(float_exec_pkg::float_add_op, 6'h00, 6'h00, 8'h09, 1'b0);
  endtask

  // Reset in flight clears every output except issue_ready, which goes high, then work resumes
  task automatic t_reset;
    start(float_exec_pkg::float_divide_op, 6'h00, 6'h3F);
    repeat (4) @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("reset_busy", 64'h0, 64'(busy));
    chk("reset_ready", 64'h1, 64'(issue_ready));
    chk("reset_done", 64'h0, 64'(done));
    chk("reset_latency", 64'h0, 64'(latency_taken));
    chk("reset_wr_data", 64'h0, wr_data);
    chk("reset_wr_upper", 64'h0, 64'(wr_upper));
    @(posedge clk);
    rst_b <= 1'b1;
    run(float_exec_pkg::move_op, 6'h00, 6'h00, 8'h04, 1'b0);
  endtask

  task automatic t_busy;
    mode(4'h0);
    start(float_exec_pkg::float_divide_op, 6'h00, 6'h3F);
    repeat (6) @(posedge clk);
    #1;
    chk("issue_ready", 64'h0, 64'(issue_ready));
    chk("busy", 64'h1, 64'(busy));
    chk("done", 64'h0, 64'(done));
    finish_run(8'h25, 1'b0);
  endtask

  initial begin
    #200000;
    mismatches++;
    summarize();
  end

  initial begin
    rst_b = 1'b0;
    go = 1'b0;
    op = float_exec_pkg::float_add_op;
    {double_prec, short_vector, fast_float_mode, flush_to_zero} = 4'h0;
    {operand_special, subnormal_count, inter_subnormal, result_subnormal} = 5'h00;
    penalty_high = 1'b0;
    extra_work = 6'h00;
    fast_value = 32'hC3A5_5A3C;
    upper_half = 1'b0;
    reg_old = 64'h0123_4567_89AB_CDEF;
    mismatches = 0;
    checks = 0;
    repeat (7) @(posedge clk);
    #1;
    chk("reset_ready", 64'h1, 64'(issue_ready));
    chk("reset_busy", 64'h0, 64'(busy));
    @(posedge clk);
    rst_b <= 1'b1;
    t_fixed();
    t_ranges();
    t_penalty();
    t_fast();
    t_reset();
    t_busy();
    summarize();
  end
endmodule
